/* logic/gpcf_pkg.sv */
// package: register map, widths and reset values of the port block
package gpcf_pkg;
    // printed offsets are not all multiples of four: they are word indices
    localparam logic [7:0] port_c_pin_data_idx = 8'h02;
    localparam logic [7:0] port_d_pin_data_idx = 8'h03;
    localparam logic [7:0] port_c_direction_idx = 8'h06;
    localparam logic [7:0] port_e_pin_data_idx = 8'h08;
    localparam logic [7:0] port_f_pin_data_idx = 8'h09;
    localparam logic [7:0] port_e_direction_idx = 8'h0c;
    localparam logic [7:0] port_f_direction_idx = 8'h0d;
    localparam int idx_lsb = 2;
    localparam int port_c_width = 7;
    localparam int port_d_width = 7;
    localparam int port_e_width = 8;
    localparam int port_f_width = 6;
    localparam logic [7:0] direction_reset = 8'h00;
    localparam logic [31:0] unmapped_read = 32'h00000000;
endpackage

/* logic/gpcf_port_if.sv */
// interface: pin side of one port, between the top and a port slice
interface gpcf_port_if #(parameter int width = 8);
    logic [width-1:0] pin_level;
    logic [width-1:0] latch;
    logic [width-1:0] direction;
    logic [width-1:0] periph_own;
    logic [width-1:0] periph_oe;
    logic [width-1:0] periph_out;
    logic [width-1:0] read_value;
    logic [width-1:0] drive_en;
    logic [width-1:0] drive_value;
    modport slice (
        input pin_level, latch, direction, periph_own, periph_oe, periph_out,
        output read_value, drive_en, drive_value
    );
    modport top (
        output pin_level, latch, direction, periph_own, periph_oe, periph_out,
        input read_value, drive_en, drive_value
    );
endinterface

/* logic/gpcf_sync.sv */
// two-stage synchroniser for a bus of pin levels
module gpcf_sync #(
    parameter int width = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] stage1;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* logic/gpcf_slice.sv */
// per-bit read mux and output driver of one port
module gpcf_slice (
    gpcf_port_if.slice p
);
    // direction picks read source even for pins a peripheral owns
    assign p.read_value = (p.direction & p.latch)
                        | (~p.direction & p.pin_level);
    // a peripheral that owns a pin decides its direction itself
    assign p.drive_en = (p.periph_own & p.periph_oe)
                      | (~p.periph_own & p.direction);
    assign p.drive_value = (p.periph_own & p.periph_out)
                         | (~p.periph_own & p.latch);
endmodule

/* logic/gpcf_ports.sv */
// top: parallel ports c, d, e, f with an apb register slave
// Notes on behaviour
// - reset clears all direction registers so c, e, f pins start as inputs.
// - direction one enables the pin driver; zero leaves the pin undriven.
// - with direction zero, data reads return the synchronised pin level.
// - port c data decoded at its index; output bits read back the latch.
// - port e data decoded at its index; output bits read back the latch.
// - port f data decoded at its index; output bits read back the latch.
// - data writes with pstrb bit 0 set update the latch, whatever the direction.
// - writes to input pins touch only the latch, not pin or read value.
// - port d is seven input-only bits; reads give pins, writes the latch.
// - reset leaves every data latch unchanged.
// - port e has eight bits; timers take five, serial takes two.
// - timer-owned port e pins follow timer direction; direction picks reads.
// - port f has six bits; spi takes four, serial two; direction picks reads.
// - spi or serial ownership of a port f pin overrides its direction bit.
//
// The implementer's own choice: register access over APB.
module gpcf_ports #(
    parameter int c_w = gpcf_pkg::port_c_width,
    parameter int d_w = gpcf_pkg::port_d_width,
    parameter int e_w = gpcf_pkg::port_e_width,
    parameter int f_w = gpcf_pkg::port_f_width
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [c_w-1:0] port_c_pin_in,
    output logic [c_w-1:0] port_c_pin_out,
    output logic [c_w-1:0] port_c_pin_oe_out,
    input wire logic [d_w-1:0] port_d_pin_in,
    input wire logic [e_w-1:0] port_e_pin_in,
    output logic [e_w-1:0] port_e_pin_out,
    output logic [e_w-1:0] port_e_pin_oe_out,
    input wire logic [e_w-1:0] port_e_periph_own_in,
    input wire logic [e_w-1:0] port_e_periph_oe_in,
    input wire logic [e_w-1:0] port_e_periph_out_in,
    input wire logic [f_w-1:0] port_f_pin_in,
    output logic [f_w-1:0] port_f_pin_out,
    output logic [f_w-1:0] port_f_pin_oe_out,
    input wire logic [f_w-1:0] port_f_periph_own_in,
    input wire logic [f_w-1:0] port_f_periph_oe_in,
    input wire logic [f_w-1:0] port_f_periph_out_in,
    output logic [e_w-1:0] port_e_pin_sync_out,
    output logic [f_w-1:0] port_f_pin_sync_out
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [c_w-1:0] port_c_latch;
    logic [d_w-1:0] port_d_latch;
    logic [e_w-1:0] port_e_latch;
    logic [f_w-1:0] port_f_latch;
    logic [c_w-1:0] port_c_direction;
    logic [e_w-1:0] port_e_direction;
    logic [f_w-1:0] port_f_direction;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [c_w-1:0] c_sync;
    logic [d_w-1:0] d_sync;
    logic [e_w-1:0] e_sync;
    logic [f_w-1:0] f_sync;

    gpcf_sync #(.width(c_w)) u_sync_c (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .async_in(port_c_pin_in), .sync_out(c_sync)
    );
    gpcf_sync #(.width(d_w)) u_sync_d (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .async_in(port_d_pin_in), .sync_out(d_sync)
    );
    gpcf_sync #(.width(e_w)) u_sync_e (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .async_in(port_e_pin_in), .sync_out(e_sync)
    );
    gpcf_sync #(.width(f_w)) u_sync_f (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .async_in(port_f_pin_in), .sync_out(f_sync)
    );

    // ------------------------------------------------------------
    // port slices
    // ------------------------------------------------------------
    gpcf_port_if #(.width(c_w)) pc ();
    gpcf_port_if #(.width(e_w)) pe ();
    gpcf_port_if #(.width(f_w)) pf ();

    assign pc.pin_level = c_sync;
    assign pc.latch = port_c_latch;
    assign pc.direction = port_c_direction;
    assign pc.periph_own = '0;
    assign pc.periph_oe = '0;
    assign pc.periph_out = '0;

    assign pe.pin_level = e_sync;
    assign pe.latch = port_e_latch;
    assign pe.direction = port_e_direction;
    assign pe.periph_own = port_e_periph_own_in;
    assign pe.periph_oe = port_e_periph_oe_in;
    assign pe.periph_out = port_e_periph_out_in;

    assign pf.pin_level = f_sync;
    assign pf.latch = port_f_latch;
    assign pf.direction = port_f_direction;
    assign pf.periph_own = port_f_periph_own_in;
    assign pf.periph_oe = port_f_periph_oe_in;
    assign pf.periph_out = port_f_periph_out_in;

    gpcf_slice u_slice_c (.p(pc.slice));
    gpcf_slice u_slice_e (.p(pe.slice));
    gpcf_slice u_slice_f (.p(pf.slice));

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    localparam int idx_lsb_c = gpcf_pkg::idx_lsb;
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[11:idx_lsb_c] == {2'h0, idx}) && (a[1:0] == 2'h0);
    endfunction

    wire access = psel_in && penable_in && ce_in;
    wire wr = access && pwrite_in && pstrb_in[0];
    wire sel_c = hit(paddr_in, gpcf_pkg::port_c_pin_data_idx);
    wire sel_d = hit(paddr_in, gpcf_pkg::port_d_pin_data_idx);
    wire sel_e = hit(paddr_in, gpcf_pkg::port_e_pin_data_idx);
    wire sel_f = hit(paddr_in, gpcf_pkg::port_f_pin_data_idx);
    wire sel_dc = hit(paddr_in, gpcf_pkg::port_c_direction_idx);
    wire sel_de = hit(paddr_in, gpcf_pkg::port_e_direction_idx);
    wire sel_df = hit(paddr_in, gpcf_pkg::port_f_direction_idx);
    wire mapped = sel_c | sel_d | sel_e | sel_f | sel_dc | sel_de | sel_df;

    // read mux: upper bits stay zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = gpcf_pkg::unmapped_read;
        if (sel_c) begin
            next_rdata[c_w-1:0] = pc.read_value;
        end else if (sel_d) begin
            next_rdata[d_w-1:0] = d_sync;
        end else if (sel_e) begin
            next_rdata[e_w-1:0] = pe.read_value;
        end else if (sel_f) begin
            next_rdata[f_w-1:0] = pf.read_value;
        end else if (sel_dc) begin
            next_rdata[c_w-1:0] = port_c_direction;
        end else if (sel_de) begin
            next_rdata[e_w-1:0] = port_e_direction;
        end else if (sel_df) begin
            next_rdata[f_w-1:0] = port_f_direction;
        end
    end

    // ------------------------------------------------------------
    // apb response: zero wait states, registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= '0;
            pslverr_out <= 1'b0;
            pready_out <= 1'b0;
        end else if (ce_in) begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && !mapped;
            if (psel_in && !penable_in && !pwrite_in) begin
                prdata_out <= next_rdata;
            end
        end
    end

    wire wr_done = wr && pready_out;

    // ------------------------------------------------------------
    // data latches: no reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (wr_done && sel_c) begin
            port_c_latch <= pwdata_in[c_w-1:0];
        end
        if (wr_done && sel_d) begin
            port_d_latch <= pwdata_in[d_w-1:0];
        end
        if (wr_done && sel_e) begin
            port_e_latch <= pwdata_in[e_w-1:0];
        end
        if (wr_done && sel_f) begin
            port_f_latch <= pwdata_in[f_w-1:0];
        end
    end

    // ------------------------------------------------------------
    // direction registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_c_direction <= gpcf_pkg::direction_reset[c_w-1:0];
            port_e_direction <= gpcf_pkg::direction_reset[e_w-1:0];
            port_f_direction <= gpcf_pkg::direction_reset[f_w-1:0];
        end else begin
            if (wr_done && sel_dc) begin
                port_c_direction <= pwdata_in[c_w-1:0];
            end
            if (wr_done && sel_de) begin
                port_e_direction <= pwdata_in[e_w-1:0];
            end
            if (wr_done && sel_df) begin
                port_f_direction <= pwdata_in[f_w-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers, registered; software may avoid glitches by
    // writing the latch before the direction
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_c_pin_out <= '0;
            port_c_pin_oe_out <= '0;
            port_e_pin_out <= '0;
            port_e_pin_oe_out <= '0;
            port_f_pin_out <= '0;
            port_f_pin_oe_out <= '0;
            port_e_pin_sync_out <= '0;
            port_f_pin_sync_out <= '0;
        end else if (ce_in) begin
            port_c_pin_oe_out <= pc.drive_en;
            port_c_pin_out <= pc.drive_value;
            port_e_pin_oe_out <= pe.drive_en;
            port_e_pin_out <= pe.drive_value;
            port_f_pin_oe_out <= pf.drive_en;
            port_f_pin_out <= pf.drive_value;
            port_e_pin_sync_out <= e_sync;
            port_f_pin_sync_out <= f_sync;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_dir_reset_zero: assert property (@(posedge clk_in)
        $fell(rst_in) |-> (port_c_direction == '0 && port_e_direction == '0
                           && port_f_direction == '0))
        else $error("direction not cleared by reset");

    a_c_oe_follow: assert property (@(posedge clk_in)
        disable iff (rst_in)
        ce_in |=> port_c_pin_oe_out == $past(port_c_direction))
        else $error("port c enable does not follow direction");

    a_c_pin_drive: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (wr_done && sel_c) ##1 ce_in
        |=> port_c_pin_out == $past(port_c_latch))
        else $error("port c output does not follow latch");

    a_c_read_pin: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in && !pwrite_in && sel_c)
        |=> prdata_out[c_w-1:0] ==
            $past((port_c_direction & port_c_latch) |
                  (~port_c_direction & c_sync)))
        else $error("port c read source wrong");

    a_c_write_latch: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (wr_done && sel_c) |=> port_c_latch == $past(pwdata_in[c_w-1:0]))
        else $error("port c latch not written");

    a_c_dir_upper: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in && !pwrite_in && sel_dc)
        |=> prdata_out[31:c_w] == '0)
        else $error("port c direction upper bits not zero");

    a_d_read_pin: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in && !pwrite_in && sel_d)
        |=> prdata_out == {{(32-d_w){1'b0}}, $past(d_sync)})
        else $error("port d read is not the pin");

    a_d_write_latch: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (wr_done && sel_d) |=> port_d_latch == $past(pwdata_in[d_w-1:0]))
        else $error("port d latch not written");

    a_e_write_latch: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (wr_done && sel_e) |=> port_e_latch == $past(pwdata_in[e_w-1:0]))
        else $error("port e latch not written");

    a_e_read_src: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in && !pwrite_in && sel_e)
        |=> prdata_out[e_w-1:0] ==
            $past((port_e_direction & port_e_latch) |
                  (~port_e_direction & e_sync)))
        else $error("port e read source wrong");

    a_e_owned_oe: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && port_e_periph_own_in[0])
        |=> port_e_pin_oe_out[0] == $past(port_e_periph_oe_in[0]))
        else $error("port e direction overrides timer");

    a_e_free_oe: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && !port_e_periph_own_in[e_w-1])
        |=> port_e_pin_oe_out[e_w-1] == $past(port_e_direction[e_w-1]))
        else $error("port e enable does not follow direction");

    a_f_write_latch: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (wr_done && sel_f) |=> port_f_latch == $past(pwdata_in[f_w-1:0]))
        else $error("port f latch not written");

    a_f_read_src: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in && !pwrite_in && sel_f)
        |=> prdata_out[f_w-1:0] ==
            $past((port_f_direction & port_f_latch) |
                  (~port_f_direction & f_sync)))
        else $error("port f read source wrong");

    a_f_owned_oe: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && port_f_periph_own_in[0])
        |=> port_f_pin_oe_out[0] == $past(port_f_periph_oe_in[0]))
        else $error("port f direction overrides peripheral");

    a_f_free_oe: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && !port_f_periph_own_in[f_w-1])
        |=> port_f_pin_oe_out[f_w-1] == $past(port_f_direction[f_w-1]))
        else $error("port f enable does not follow direction");

    a_f_upper_zero: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in && !pwrite_in && sel_f)
        |=> prdata_out[31:f_w] == '0)
        else $error("port f upper bits not zero");

    a_ready_pulse: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (ce_in && psel_in && !penable_in) |=> pready_out)
        else $error("no ready after setup");
endmodule

/* tb/gpcf_pins_model.sv */
// pin-side model: the board around ports c, e and f
module gpcf_pins_model #(
    parameter int w = 8
) (
    input wire logic [w-1:0] drv_in,
    input wire logic [w-1:0] oe_in,
    input wire logic [w-1:0] board_in,
    output logic [w-1:0] wire_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // bits the block does not drive show the board's own level
    assign wire_out = (drv_in & oe_in) | (board_in & ~oe_in);
endmodule

/* tb/gpcf_ports_tb.sv */
// testbench: apb access and pin behaviour of the port block
module gpcf_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [6:0] c_out, c_oe, c_w, ext_c, ext_d;
    logic [7:0] e_out, e_oe, e_w, ext_e, e_own, e_poe, e_pout, e_sync;
    logic [5:0] f_out, f_oe, f_w, ext_f, f_own, f_poe, f_pout, f_sync;
    int n_mismatch = 0;
    int compares = 0;

    always #5 clk_in = ~clk_in;

    gpcf_ports gpcf_ports_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .port_c_pin_in(c_w),
        .port_c_pin_out(c_out), .port_c_pin_oe_out(c_oe),
        .port_d_pin_in(ext_d), .port_e_pin_in(e_w), .port_e_pin_out(e_out),
        .port_e_pin_oe_out(e_oe), .port_e_periph_own_in(e_own),
        .port_e_periph_oe_in(e_poe), .port_e_periph_out_in(e_pout),
        .port_f_pin_in(f_w), .port_f_pin_out(f_out),
        .port_f_pin_oe_out(f_oe), .port_f_periph_own_in(f_own),
        .port_f_periph_oe_in(f_poe), .port_f_periph_out_in(f_pout),
        .port_e_pin_sync_out(e_sync), .port_f_pin_sync_out(f_sync));
    gpcf_pins_model #(.w(7)) gpcf_pins_model_c_i (.drv_in(c_out),
        .oe_in(c_oe), .board_in(ext_c), .wire_out(c_w));
    gpcf_pins_model #(.w(8)) gpcf_pins_model_e_i (.drv_in(e_out),
        .oe_in(e_oe), .board_in(ext_e), .wire_out(e_w));
    gpcf_pins_model #(.w(6)) gpcf_pins_model_f_i (.drv_in(f_out),
        .oe_in(f_oe), .board_in(ext_f), .wire_out(f_w));

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk_in);
        pen <= 1'b1;
        // pready is read before this edge's updates land
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_mismatch++;
            $display("[ERR] %0t no bus answer", $time);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, d, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0, rd, err);
        chk(rd, exp);
    endtask

    // latch is loaded before the direction turns to output
    task automatic set_port(input logic [7:0] di, input logic [7:0] ri,
        input logic [31:0] lat, input logic [31:0] dir,
        input logic [31:0] pins, input logic [31:0] msk);
        wr(di, lat);
        wr(ri, dir);
        repeat (4) @(posedge clk_in);
        rd_chk(di, ((lat & dir) | (pins & ~dir)) & msk);
        rd_chk(ri, dir & msk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_dirs();
        rd_chk(gpcf_pkg::port_c_direction_idx, 32'h0);
        rd_chk(gpcf_pkg::port_e_direction_idx, 32'h0);
        rd_chk(gpcf_pkg::port_f_direction_idx, 32'h0);
        chk({11'h0, c_oe, e_oe, f_oe}, 32'h0);
    endtask

    task automatic t_port_c();
        set_port(8'h02, 8'h06, 32'hd5, 32'h00, 32'h2a, 32'h7f);
        chk({25'h0, c_oe}, 32'h0);
        set_port(8'h02, 8'h06, 32'h55, 32'hff, 32'h2a, 32'h7f);
        chk({25'h0, c_oe}, 32'h7f);
        chk({25'h0, c_out}, 32'h55);
        set_port(8'h02, 8'h06, 32'h33, 32'h0f, 32'h2a, 32'h7f);
        chk({25'h0, c_oe}, 32'h0f);
        chk({25'h0, c_out & c_oe}, 32'h03);
        pstrb <= 4'h0;
        wr(gpcf_pkg::port_c_pin_data_idx, 32'h4c);
        pstrb <= 4'hf;
        rd_chk(gpcf_pkg::port_c_pin_data_idx, 32'h23);
    endtask

    task automatic t_port_d();
        logic [31:0] rd;
        logic err;
        wr(gpcf_pkg::port_d_pin_data_idx, 32'h7f);
        rd_chk(gpcf_pkg::port_d_pin_data_idx, 32'h15);
        ext_d <= 7'h6a;
        repeat (4) @(posedge clk_in);
        rd_chk(gpcf_pkg::port_d_pin_data_idx, 32'h6a);
        apb(1'b0, 8'h0f, 32'h0, rd, err);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask

    task automatic t_port_e();
        e_own <= 8'h1f;
        e_poe <= 8'h0f;
        e_pout <= 8'h05;
        set_port(8'h08, 8'h0c, 32'h9c, 32'hf0, 32'h05, 32'hff);
        chk({24'h0, e_oe}, 32'hef);
        chk({24'h0, e_out & e_oe}, 32'h85);
        chk({24'h0, e_sync}, 32'h95);
    endtask

    task automatic t_port_f();
        f_own <= 6'h0f;
        f_poe <= 6'h05;
        f_pout <= 6'h04;
        set_port(8'h09, 8'h0d, 32'h2d, 32'h3a, 32'h2e, 32'h3f);
        chk({26'h0, f_oe}, 32'h35);
        chk({26'h0, f_out & f_oe}, 32'h24);
        chk({26'h0, f_sync}, 32'h2e);
    endtask

    // clock enable low freezes the pin synchronisers
    task automatic t_ce_hold();
        ce <= 1'b0;
        ext_f <= 6'h13;
        repeat (4) @(posedge clk_in);
        chk({26'h0, f_sync}, 32'h2e);
        ce <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk({26'h0, f_sync}, 32'h26);
    endtask

    task automatic t_reset_keep();
        e_own <= 8'h00;
        f_own <= 6'h00;
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        chk({11'h0, c_oe, e_oe, f_oe}, 32'h0);
        wr(gpcf_pkg::port_c_direction_idx, 32'h7f);
        wr(gpcf_pkg::port_e_direction_idx, 32'hff);
        wr(gpcf_pkg::port_f_direction_idx, 32'h3f);
        rd_chk(gpcf_pkg::port_c_pin_data_idx, 32'h33);
        rd_chk(gpcf_pkg::port_e_pin_data_idx, 32'h9c);
        rd_chk(gpcf_pkg::port_f_pin_data_idx, 32'h2d);
    endtask

    initial begin
        ext_c = 7'h2a;
        ext_d = 7'h15;
        ext_e = 8'h3c;
        ext_f = 6'h1b;
        {e_own, e_poe, e_pout} = 24'h0;
        {f_own, f_poe, f_pout} = 18'h0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset_dirs();
        t_port_c();
        t_port_d();
        t_port_e();
        t_port_f();
        t_ce_hold();
        t_reset_keep();
        wrap_up();
    end
endmodule
